//--- dtr_timing.sv
// Device-side command timing tracker for a DDR2 memory.
// Functional notes
// - Termination turns on two clock cycles after the edge that first sampled its control high.
// - Termination turns off half a period after the second trailing edge from the first low sample.
// - The precharge picosecond parameter becomes its value divided by the clock period, rounded up, and is honoured.
// - Activate may follow precharge after the rounded-up precharge cycle count.
// - Delays count real clock edges; activate may follow power-down exit three edges later.
// - Mode register bit 10 clear enables the differential strobe, referencing input timing to it.
`timescale 1ns/100ps
`include "dtr_defs.svh"
module dtr_timing #(
	parameter int PRECHARGE_PS = `DTR_PRECHARGE_PS,
	parameter int CLOCK_PS = `DTR_CLOCK_PS
) (
	input wire logic clk,
	input wire logic rst,
	input wire dtr_pkg::dtr_cmd_s cmd_in,
	input wire logic [3:0] write_recovery,
	input wire logic termination_control,
	input wire logic clock_gate,
	input wire logic [12:0] mode_register,
	output logic termination_on,
	output logic termination_half_phase,
	output logic diff_strobe_en,
	output dtr_pkg::dtr_status_s status
);
	// round the precharge period up to whole cycles.
	localparam int PRE_CYC_INT = (PRECHARGE_PS + CLOCK_PS - 1) / CLOCK_PS;
	localparam logic [4:0] PRE_CYC = PRE_CYC_INT[4:0];

	initial begin
		if (PRE_CYC_INT < 1 || PRE_CYC_INT > 15 || CLOCK_PS < 1) begin
			$error("dtr_timing: precharge cycle count out of range");
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic odt_s1_reg;
	logic odt_s2_reg;
	logic cke_s1_reg;
	logic cke_s2_reg;

	// Pins come from outside this clock domain; two stages before use.
	always_ff @(posedge clk) begin
		if (rst) begin
			odt_s1_reg <= 1'b0;
			odt_s2_reg <= 1'b0;
			cke_s1_reg <= 1'b0;
			cke_s2_reg <= 1'b0;
		end else begin
			odt_s1_reg <= termination_control;
			odt_s2_reg <= odt_s1_reg;
			cke_s1_reg <= clock_gate;
			cke_s2_reg <= cke_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Termination control
	// ----------------------------------------------------------------
	dtr_pkg::dtr_term_e term_state_reg;
	logic [2:0] term_cnt_reg;

	// The count restarts on the first opposite sample, so a short glitch restarts the delay.
	always_ff @(posedge clk) begin
		if (rst) begin
			term_state_reg <= dtr_pkg::DTR_TS_OFF;
			term_cnt_reg <= 3'h0;
		end else begin
			case (term_state_reg)
				dtr_pkg::DTR_TS_OFF: begin
					if (odt_s2_reg) begin
						term_state_reg <= dtr_pkg::DTR_TS_TURN_ON;
						term_cnt_reg <= 3'h1;
					end
				end
				dtr_pkg::DTR_TS_TURN_ON: begin
					if (!odt_s2_reg) begin
						term_state_reg <= dtr_pkg::DTR_TS_OFF;
					end else if (term_cnt_reg == `DTR_TERM_ON_CYCLES - 3'h1) begin
						term_state_reg <= dtr_pkg::DTR_TS_ON;
					end else begin
						term_cnt_reg <= term_cnt_reg + 3'h1;
					end
				end
				dtr_pkg::DTR_TS_ON: begin
					if (!odt_s2_reg) begin
						term_state_reg <= dtr_pkg::DTR_TS_TURN_OFF;
						term_cnt_reg <= 3'h1;
					end
				end
				dtr_pkg::DTR_TS_TURN_OFF: begin
					// off after the second trailing edge plus half a period.
					if (odt_s2_reg) begin
						term_state_reg <= dtr_pkg::DTR_TS_ON;
					end else if (term_cnt_reg == `DTR_TERM_OFF_EDGES) begin
						term_state_reg <= dtr_pkg::DTR_TS_OFF;
					end else begin
						term_cnt_reg <= term_cnt_reg + 3'h1;
					end
				end
				default: begin
					term_state_reg <= dtr_pkg::DTR_TS_OFF;
				end
			endcase
		end
	end

	// Registered outputs; the half-phase flag marks the half period of turn-off.
	always_ff @(posedge clk) begin
		if (rst) begin
			termination_on <= 1'b0;
			termination_half_phase <= 1'b0;
		end else begin
			termination_on <= (term_state_reg == dtr_pkg::DTR_TS_ON) || (term_state_reg == dtr_pkg::DTR_TS_TURN_OFF);
			termination_half_phase <= (term_state_reg == dtr_pkg::DTR_TS_TURN_OFF) &&
				(term_cnt_reg == `DTR_TERM_OFF_EDGES) && !odt_s2_reg;
		end
	end

	// ----------------------------------------------------------------
	// Strobe mode
	// ----------------------------------------------------------------
	// differential strobe when bit 10 is clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			diff_strobe_en <= 1'b1;
		end else begin
			diff_strobe_en <= !mode_register[`DTR_MR_DQS_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Command spacing counters
	// ----------------------------------------------------------------
	logic [4:0] act_cnt_reg;
	logic [3:0] wtr_cnt_reg;
	logic [2:0] cke_cnt_reg;
	logic cke_prev_reg;
	logic is_act;
	logic is_rd;

	assign is_act = cmd_in.valid && (cmd_in.cmd == dtr_pkg::DTR_CMD_ACT);
	assign is_rd = cmd_in.valid && (cmd_in.cmd == dtr_pkg::DTR_CMD_RD);

	// precharge, autoprecharge and exit load the activate guard.
	always_ff @(posedge clk) begin
		if (rst) begin
			act_cnt_reg <= 5'h0;
		end else if (cmd_in.valid && cmd_in.cmd == dtr_pkg::DTR_CMD_PRE) begin
			// Loaded one short, so the command exactly n edges later sees zero and is legal.
			act_cnt_reg <= PRE_CYC - 5'h1;
		end else if (cmd_in.valid && cmd_in.cmd == dtr_pkg::DTR_CMD_WRA) begin
			act_cnt_reg <= {1'b0, write_recovery} + PRE_CYC - 5'h1;
		end else if (cmd_in.valid && cmd_in.cmd == dtr_pkg::DTR_CMD_PDX) begin
			act_cnt_reg <= {1'b0, `DTR_XP_CYCLES} - 5'h1;
		end else if (act_cnt_reg != 5'h0) begin
			act_cnt_reg <= act_cnt_reg - 5'h1;
		end
	end

	// two cycles from write to read.
	always_ff @(posedge clk) begin
		if (rst) begin
			wtr_cnt_reg <= 4'h0;
		end else if (cmd_in.valid && (cmd_in.cmd == dtr_pkg::DTR_CMD_WR || cmd_in.cmd == dtr_pkg::DTR_CMD_WRA)) begin
			wtr_cnt_reg <= `DTR_WTR_MIN - 4'h1;
		end else if (wtr_cnt_reg != 4'h0) begin
			wtr_cnt_reg <= wtr_cnt_reg - 4'h1;
		end
	end

	// count edges the clock enable holds its level.
	always_ff @(posedge clk) begin
		if (rst) begin
			cke_prev_reg <= 1'b0;
			cke_cnt_reg <= `DTR_CKE_MIN;
		end else begin
			cke_prev_reg <= cke_s2_reg;
			if (cke_s2_reg != cke_prev_reg) begin
				cke_cnt_reg <= 3'h1;
			end else if (cke_cnt_reg != `DTR_CKE_MIN) begin
				cke_cnt_reg <= cke_cnt_reg + 3'h1;
			end
		end
	end

	// Sticky violation flags; only reset clears them, so no event is lost.
	always_ff @(posedge clk) begin
		if (rst) begin
			status <= '0;
		end else begin
			status.act_allowed <= (act_cnt_reg <= 5'h1) && !is_act;
			status.read_allowed <= (wtr_cnt_reg <= 4'h1);
			status.act_violation <= status.act_violation || (is_act && act_cnt_reg != 5'h0);
			status.wtr_violation <= status.wtr_violation || (is_rd && wtr_cnt_reg != 4'h0);
			status.cke_violation <= status.cke_violation ||
				((cke_s2_reg != cke_prev_reg) && cke_cnt_reg != `DTR_CKE_MIN);
		end
	end
endmodule

//--- dtr_defs.svh
// Timing constants for the DDR2 command timing block.
`ifndef DTR_DEFS_SVH
`define DTR_DEFS_SVH
// Termination turn-on point, in clock cycles after the sampling edge.
`define DTR_TERM_ON_CYCLES 3'h2
// Termination turn-off point, in trailing edges after the sampling edge.
`define DTR_TERM_OFF_EDGES 3'h2
// Least write-to-read spacing in clock cycles.
`define DTR_WTR_MIN 4'h2
// Clock enable must be registered on this many consecutive edges.
`define DTR_CKE_MIN 3'h3
// Power-down exit to activate, in clock edges.
`define DTR_XP_CYCLES 4'h3
// Default precharge period in picoseconds and clock period in picoseconds.
`define DTR_PRECHARGE_PS 32'd13125
`define DTR_CLOCK_PS 32'd100000
// Mode register bit that disables the differential strobe.
`define DTR_MR_DQS_BIT 10
`endif

//--- dtr_pkg.sv
// Types shared by the DDR2 command timing block.
package dtr_pkg;
	// Decoded command presented on one clock edge.
	typedef enum logic [2:0] {
		DTR_CMD_NOP = 3'h0,
		DTR_CMD_ACT = 3'h1,
		DTR_CMD_RD = 3'h2,
		DTR_CMD_WR = 3'h3,
		DTR_CMD_PRE = 3'h4,
		DTR_CMD_WRA = 3'h5,
		DTR_CMD_PDX = 3'h6
	} dtr_cmd_e;
	// Command input group.
	typedef struct packed {
		logic valid;
		dtr_cmd_e cmd;
	} dtr_cmd_s;
	// Termination state machine.
	typedef enum logic [1:0] {
		DTR_TS_OFF = 2'h0,
		DTR_TS_TURN_ON = 2'h1,
		DTR_TS_ON = 2'h2,
		DTR_TS_TURN_OFF = 2'h3
	} dtr_term_e;
	// Status flags reported by the block.
	typedef struct packed {
		logic act_allowed;
		logic read_allowed;
		logic cke_violation;
		logic wtr_violation;
		logic act_violation;
	} dtr_status_s;
endpackage

//--- dtr_timing_asserts.sv
// Assertion checker for the DDR2 command timing block.
`timescale 1ns/100ps
module dtr_timing_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire dtr_pkg::dtr_cmd_s cmd_in,
	input wire logic termination_control,
	input wire logic clock_gate,
	input wire logic [12:0] mode_register,
	input wire logic termination_on,
	input wire logic termination_half_phase,
	input wire logic diff_strobe_en,
	input wire dtr_pkg::dtr_status_s status
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Command decodes seen on the sampling edge.
	wire pre = cmd_in.valid && cmd_in.cmd == dtr_pkg::DTR_CMD_PRE;
	wire act = cmd_in.valid && cmd_in.cmd == dtr_pkg::DTR_CMD_ACT;
	wire wr = cmd_in.valid && cmd_in.cmd == dtr_pkg::DTR_CMD_WR;
	wire rd = cmd_in.valid && cmd_in.cmd == dtr_pkg::DTR_CMD_RD;
	a_strobe_follow: assert property (!$past(rst) |-> diff_strobe_en == !$past(mode_register[10]))
		else $error("strobe enable mismatch");
	a_term_on_late: assert property ($rose(termination_control) ##1 termination_control [*6] |-> termination_on)
		else $error("termination not on");
	a_term_off_late: assert property ($fell(termination_control) ##1 !termination_control [*7] |-> !termination_on)
		else $error("termination not off");
	a_half_phase_end: assert property (termination_half_phase |-> termination_on ##1 !(termination_on || termination_half_phase))
		else $error("half phase pulse misplaced");
	a_act_too_early: assert property (pre ##1 act |-> ##[1:3] status.act_violation)
		else $error("early activate not flagged");
	a_read_too_early: assert property (wr ##1 rd |-> ##[1:3] status.wtr_violation)
		else $error("early read not flagged");
	a_cke_short: assert property ($rose(clock_gate) ##[1:2] $fell(clock_gate) |-> ##[1:8] status.cke_violation)
		else $error("short clock enable not flagged");
	a_flags_sticky: assert property (!($fell(status.act_violation) || $fell(status.wtr_violation) || $fell(status.cke_violation)))
		else $error("violation flag cleared");
	c_pre_act: cover property (pre ##[1:3] act);
	c_half_phase: cover property (termination_half_phase);
	c_cke_flag: cover property ($rose(status.cke_violation));
endmodule

//--- dtr_ctl_model.sv
// Controller model that puts one command on the bus per request.
`timescale 1ns/100ps
module dtr_ctl_model (
	input wire logic clk,
	input wire logic go,
	input wire dtr_pkg::dtr_cmd_e op,
	output dtr_pkg::dtr_cmd_s cmd
);
	// spacing from caller.
	// An idle bus inverts the code on every edge; valid stays low, so stale values never look valid.
	always_ff @(posedge clk) begin
		cmd.valid <= go;
		cmd.cmd <= go ? op : dtr_pkg::dtr_cmd_e'(~cmd.cmd);
	end
endmodule

//--- dtr_timing_tb_top.sv
// Testbench top for the DDR2 command timing block.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module dtr_timing_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	logic termination_control = 1'b0;
	logic clock_gate = 1'b0;
	logic termination_on;
	logic termination_half_phase;
	logic diff_strobe_en;
	logic [3:0] seen;
	logic [12:0] mode_register = 13'h0000;
	dtr_pkg::dtr_cmd_e op = dtr_pkg::DTR_CMD_NOP;
	dtr_pkg::dtr_cmd_s cmd_in;
	dtr_pkg::dtr_status_s status;
	int failures = 0;
	int n_compared = 0;
	// Free-running 10 MHz clock.
	initial begin
		forever #50 clk = ~clk;
	end
	dtr_ctl_model i_dtr_ctl_model(.clk(clk), .go(go), .op(op), .cmd(cmd_in));
	// Precharge of 2.5 periods rounds up to 3 cycles.
	dtr_timing #(.PRECHARGE_PS(250000), .CLOCK_PS(100000)) i_dtr_timing(.clk(clk), .rst(rst), .cmd_in(cmd_in),
		.write_recovery(4'h2), .termination_control(termination_control), .clock_gate(clock_gate),
		.mode_register(mode_register), .termination_on(termination_on),
		.termination_half_phase(termination_half_phase), .diff_strobe_en(diff_strobe_en), .status(status));
	task automatic end_of_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Codes: 1 ACT, 2 RD, 3 WR, 4 PRE, 5 WRA, 6 PDX; next command lands gap+1 edges later.
	task automatic send(input logic [2:0] c, input int gap);
		go <= 1'b1;
		op <= dtr_pkg::dtr_cmd_e'(c);
		@(posedge clk);
		if (gap > 0) begin
			go <= 1'b0;
			repeat (gap) @(posedge clk);
		end
	endtask
	// Sample after the edge so registered outputs have settled.
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	// Each activate and read placed exactly at its earliest legal edge.
	task automatic s_legal();
		@(posedge clk);
		send(3'h4, 2);
		send(3'h1, 2);
		send(3'h6, 2);
		send(3'h1, 2);
		send(3'h3, 1);
		send(3'h2, 2);
		send(3'h5, 4);
		send(3'h1, 4);
		wait_n(1);
		`CHK(status, 5'h18)
	endtask
	// Too-close pairs and a short clock enable must all be flagged.
	task automatic s_bad();
		@(posedge clk);
		clock_gate <= 1'b1;
		send(3'h4, 0);
		clock_gate <= 1'b0;
		send(3'h1, 1);
		send(3'h3, 0);
		send(3'h2, 3);
		wait_n(3);
		`CHK(status[2:0], 3'h7)
	endtask
	// Termination follows its control pin with fixed lags.
	task automatic s_term();
		@(posedge clk);
		termination_control <= 1'b1;
		wait_n(8);
		`CHK(termination_on, 1'b1)
		@(posedge clk);
		termination_control <= 1'b0;
		seen = 4'h0;
		repeat (10) begin
			wait_n(1);
			seen = seen + {3'h0, termination_half_phase};
		end
		`CHK({seen, termination_on}, 5'h02)
	endtask
	// Strobe mode tracks bit 10; a mid-run reset clears sticky flags.
	task automatic s_reset();
		@(posedge clk);
		mode_register <= 13'h0400;
		wait_n(2);
		`CHK(diff_strobe_en, 1'b0)
		@(posedge clk);
		rst <= 1'b1;
		wait_n(3);
		`CHK({diff_strobe_en, status}, 6'h20)
		@(posedge clk);
		rst <= 1'b0;
		mode_register <= 13'h0000;
	endtask
	// Main sequence; the legal pass runs again after the mid-run reset.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		wait_n(3);
		s_term();
		s_legal();
		s_bad();
		s_reset();
		s_legal();
		end_of_test();
	end
	// Watchdog cuts a hang short.
	initial begin
		repeat (2000) @(posedge clk);
		failures++;
		end_of_test();
	end
endmodule
bind dtr_timing dtr_timing_asserts i_dtr_timing_asserts(.clk(clk), .rst(rst), .cmd_in(cmd_in),
	.termination_control(termination_control), .clock_gate(clock_gate), .mode_register(mode_register),
	.termination_on(termination_on), .termination_half_phase(termination_half_phase),
	.diff_strobe_en(diff_strobe_en), .status(status));
